// ===== inc/csdd_map.svh
// register offsets, field positions, reset values and timing figures
`ifndef CSDD_MAP_SVH
`define CSDD_MAP_SVH

// --------------------
// register offsets (byte addresses)
// --------------------
`define CSDD_OFF_DIV        8'h00
`define CSDD_OFF_CLK_DELAY  8'h04
`define CSDD_OFF_REF_DELAY  8'h08
`define CSDD_OFF_CTRL       8'h0c
`define CSDD_OFF_STATUS     8'h10

// --------------------
// field positions
// --------------------
`define CSDD_DIV_W          4
`define CSDD_CLK_DELAY_W    8
`define CSDD_REF_DELAY_W    3
`define CSDD_CTRL_PD_LSB    0
`define CSDD_CTRL_REFPD_BIT 4
`define CSDD_CTRL_REFEN_LSB 5
`define CSDD_CTRL_MULT_LSB  13
`define CSDD_CTRL_CAL_BIT   15
`define CSDD_STAT_DONE_BIT  0
`define CSDD_STAT_OSC_BIT   1
`define CSDD_STAT_UNIT_LSB  2
`define CSDD_STAT_STRAP_BIT 4
`define CSDD_STAT_DIVON_LSB 8
`define CSDD_STAT_MEAS_LSB  16

// --------------------
// reset values and responses
// --------------------
`define CSDD_STRAP_IDLE     1'b1
`define CSDD_STRAP_CYCLES   2'd3
`define CSDD_RESP_OKAY      2'b00
`define CSDD_RESP_SLVERR    2'b10

// --------------------
// timing
// --------------------
`define CSDD_CLK_PERIOD_NS  25
`define CSDD_CAL_TIME_NS    10000

`endif

// ===== inc/csdd_pkg.sv
// types shared by the clock and sysref distribution block
package csdd_pkg;

   typedef enum logic [3:0] {
      CSDD_DIV1  = 4'h0,
      CSDD_DIV2  = 4'h1,
      CSDD_DIV3  = 4'h2,
      CSDD_DIV4  = 4'h3,
      CSDD_DIV6  = 4'h4,
      CSDD_DIV8  = 4'h5,
      CSDD_DIV12 = 4'h6,
      CSDD_DIV16 = 4'h7,
      CSDD_DIV24 = 4'h8
   } csdd_div_code_t;

   typedef enum logic [0:0] {
      CSDD_CAL_IDLE = 1'b0,
      CSDD_CAL_RUN  = 1'b1
   } csdd_cal_state_t;

   typedef logic [1:0] csdd_mult_t;

endpackage : csdd_pkg

// ===== design/csdd_channel.sv
// one clock channel: divider with boundary reload and period-step delay line
`timescale 1ns/1ps
`include "csdd_map.svh"

module csdd_channel #(
   parameter int DELAY_STEPS = 256,
   parameter int CNT_W       = 5
) (
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   // settings
   input  wire csdd_pkg::csdd_div_code_t     div_code_i,
   input  wire logic [$clog2(DELAY_STEPS)-1:0] delay_i,
   input  wire logic                         power_down_i,
   // outputs
   output logic                              clk_out_o,
   output logic                              divider_on_o
);
   import csdd_pkg::*;

   if (DELAY_STEPS < 2 || CNT_W < 5) begin : g_bad_param
      $error("csdd_channel: delay steps or counter width too small");
   end

   // --------------------
   // divider
   // --------------------
   function automatic logic [CNT_W-1:0] ratio_of(input csdd_div_code_t code);
      case (code)
         CSDD_DIV2:  ratio_of = CNT_W'(2);
         CSDD_DIV3:  ratio_of = CNT_W'(3);
         CSDD_DIV4:  ratio_of = CNT_W'(4);
         CSDD_DIV6:  ratio_of = CNT_W'(6);
         CSDD_DIV8:  ratio_of = CNT_W'(8);
         CSDD_DIV12: ratio_of = CNT_W'(12);
         CSDD_DIV16: ratio_of = CNT_W'(16);
         CSDD_DIV24: ratio_of = CNT_W'(24);
         default:    ratio_of = CNT_W'(1);
      endcase
   endfunction : ratio_of

   logic [CNT_W-1:0]       ratio_r;
   logic [CNT_W-1:0]       cnt_r;
   logic                   wrap;
   logic                   pulse;
   logic [DELAY_STEPS-1:0] line_r;

   assign wrap  = (cnt_r == ratio_r - CNT_W'(1));
   assign pulse = wrap & ~power_down_i;

   // a new ratio only lands on a period boundary, so no runt periods
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ratio_r <= CNT_W'(1);
         cnt_r   <= '0;
      end else if (power_down_i) begin
         cnt_r   <= '0;
         ratio_r <= ratio_of(div_code_i);
      end else if (wrap) begin
         cnt_r   <= '0;
         ratio_r <= ratio_of(div_code_i);
      end else begin
         cnt_r   <= cnt_r + CNT_W'(1);
      end
   end

   // ratio one keeps the counter parked: the divider stage is idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         divider_on_o <= 1'b0;
      end else begin
         divider_on_o <= (ratio_r != CNT_W'(1)) & ~power_down_i;
      end
   end

   // --------------------
   // phase delay, one step per input period
   // --------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || power_down_i) begin
         line_r <= '0;
      end else begin
         line_r <= {line_r[DELAY_STEPS-2:0], pulse};
      end
   end

   // every setting passes the same output flop: equal delay codes align
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_out_o <= 1'b0;
      end else if (delay_i == '0) begin
         clk_out_o <= pulse;
      end else begin
         clk_out_o <= line_r[delay_i - 1'b1];
      end
   end

endmodule : csdd_channel

// ===== design/clock_sysref_divider_delay.sv
// clock and sysref distribution: four channels, sysref delays, calibration
//
// Contract
// - divider codes 0000..1000 give ratios 1,2,3,4,6,8,12,16,24
// - ratio one bypasses the divider and keeps it idle
// - all channel dividers run in step from the input clock; each reloads its ratio at its own period end, so they can fall out of step
// - channels A and D start at divide-by-one
// - channels B and C start at three or four, per select pin
// - an open default-select pin reads as one
// - equal clock delays give aligned rising edges for any divider
// - clock delay counts input periods, 256 steps
// - each channel and each sysref output has its own delay; sysref 0..7
// - sysref unit follows calibrated oscillator times multiplier; here the step is the input period times the latched multiplier factor
// - calibration uses the input clock as its reference
// - after calibration the oscillator stops and the stored unit stays
// - sysref outputs with equal delays switch together
// - channels and unused blocks can be powered down by software
// - settings are written and read back over the control port
// - four channels A..D each with clocks and several sysref outputs; here one clock output each, with eight sysref outputs shared by all
// - multiplier codes 00..11 give factors 1..4, also final divider
// - software sets calibration start; hardware clears it at the end
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "csdd_map.svh"

module clock_sysref_divider_delay #(
   parameter int NUM_CH      = 4,
   parameter int NUM_REF     = 8,
   parameter int DELAY_STEPS = 256,
   parameter int REF_STEPS   = 8,
   parameter int CAL_CYCLES  = (`CSDD_CAL_TIME_NS + `CSDD_CLK_PERIOD_NS - 1)
                               / `CSDD_CLK_PERIOD_NS
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // axi4-lite write address and data
   input  wire logic                 s_axi_awvalid_i,
   output logic                      s_axi_awready_o,
   input  wire logic [7:0]           s_axi_awaddr_i,
   input  wire logic                 s_axi_wvalid_i,
   output logic                      s_axi_wready_o,
   input  wire logic [31:0]          s_axi_wdata_i,
   input  wire logic [3:0]           s_axi_wstrb_i,
   // axi4-lite write response
   output logic                      s_axi_bvalid_o,
   input  wire logic                 s_axi_bready_i,
   output logic [1:0]                s_axi_bresp_o,
   // axi4-lite read
   input  wire logic                 s_axi_arvalid_i,
   output logic                      s_axi_arready_o,
   input  wire logic [7:0]           s_axi_araddr_i,
   output logic                      s_axi_rvalid_o,
   input  wire logic                 s_axi_rready_i,
   output logic [31:0]               s_axi_rdata_o,
   output logic [1:0]                s_axi_rresp_o,
   // pins
   input  wire logic                 bc_divider_default_select_i,
   input  wire logic                 sysref_i,
   output logic [NUM_CH-1:0]         channel_clock_output_o,
   output logic [NUM_REF-1:0]        sysref_output_o,
   output logic                      calibration_oscillator_o
);
   import csdd_pkg::*;

   localparam int CD_W    = $clog2(DELAY_STEPS);
   localparam int TAP_MAX = (REF_STEPS - 1) * 4;
   localparam int TAP_W   = $clog2(TAP_MAX + 1);
   localparam int CAL_W   = $clog2(CAL_CYCLES + 1);

   if (NUM_CH != 4 || NUM_REF != 8 || REF_STEPS != 8 || CD_W != 8
       || CAL_CYCLES < 1) begin : g_bad_param
      $error("clock_sysref_divider_delay: unsupported parameter set");
   end

   // --------------------
   // helpers
   // --------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // sysref tap: delay code times multiplier factor (code plus one)
   function automatic logic [TAP_W-1:0] tap_of(input logic [2:0] dly,
                                               input csdd_mult_t unit);
      logic [TAP_W-1:0] f;
      f = TAP_W'(unit) + TAP_W'(1);
      return TAP_W'(TAP_W'(dly) * f);
   endfunction : tap_of

   // --------------------
   // registers
   // --------------------
   logic [15:0]          div_r;
   logic [31:0]          cdly_r;
   logic [23:0]          rdly_r;
   logic [NUM_CH-1:0]    ch_pd_r;
   logic                 ref_pd_r;
   logic [NUM_REF-1:0]   ref_en_r;
   csdd_mult_t           mult_r;
   logic                 cal_start_r;
   csdd_mult_t           unit_r;
   logic                 cal_done_r;
   logic [15:0]          meas_r;
   logic [NUM_CH-1:0]    div_on;

   // --------------------
   // default-select strap
   // --------------------
   logic       strap_meta_r;
   logic       strap_sync_r;
   logic [1:0] boot_cnt_r;
   logic       strap_load;

   // sync flops rest at one, matching the pad pull-up on an open pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_meta_r <= `CSDD_STRAP_IDLE;
         strap_sync_r <= `CSDD_STRAP_IDLE;
      end else begin
         strap_meta_r <= bc_divider_default_select_i;
         strap_sync_r <= strap_meta_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_cnt_r <= '0;
      end else if (boot_cnt_r != `CSDD_STRAP_CYCLES) begin
         boot_cnt_r <= boot_cnt_r + 2'd1;
      end
   end

   assign strap_load = (boot_cnt_r == `CSDD_STRAP_CYCLES - 2'd1);

   // --------------------
   // axi4-lite slave
   // --------------------
   logic        aw_held_r;
   logic        w_held_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        do_write;
   logic        wr_hit;
   logic [31:0] rd_word;
   logic        rd_hit;
   logic [31:0] ctrl_word;

   assign s_axi_awready_o = ~aw_held_r;
   assign s_axi_wready_o  = ~w_held_r;
   assign s_axi_arready_o = ~s_axi_rvalid_o;
   assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
      end else if (s_axi_awvalid_i && !aw_held_r) begin
         aw_held_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr_i;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         w_held_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (s_axi_wvalid_i && !w_held_r) begin
         w_held_r <= 1'b1;
         wdata_r  <= s_axi_wdata_i;
         wstrb_r  <= s_axi_wstrb_i;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   always_comb begin
      case ({awaddr_r[7:2], 2'b00})
         `CSDD_OFF_DIV, `CSDD_OFF_CLK_DELAY, `CSDD_OFF_REF_DELAY,
         `CSDD_OFF_CTRL: wr_hit = 1'b1;
         default:        wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= `CSDD_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= wr_hit ? `CSDD_RESP_OKAY : `CSDD_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   assign ctrl_word = {16'h0000, cal_start_r, mult_r, ref_en_r, ref_pd_r, ch_pd_r};

   always_comb begin
      rd_hit  = 1'b1;
      rd_word = '0;
      case ({s_axi_araddr_i[7:2], 2'b00})
         `CSDD_OFF_DIV:       rd_word = {16'h0000, div_r};
         `CSDD_OFF_CLK_DELAY: rd_word = cdly_r;
         `CSDD_OFF_REF_DELAY: rd_word = {8'h00, rdly_r};
         `CSDD_OFF_CTRL:      rd_word = ctrl_word;
         `CSDD_OFF_STATUS: begin
            rd_word[`CSDD_STAT_DONE_BIT]               = cal_done_r;
            rd_word[`CSDD_STAT_OSC_BIT]                = calibration_oscillator_o;
            rd_word[`CSDD_STAT_UNIT_LSB +: 2]          = unit_r;
            rd_word[`CSDD_STAT_STRAP_BIT]              = strap_sync_r;
            rd_word[`CSDD_STAT_DIVON_LSB +: NUM_CH]    = div_on;
            rd_word[`CSDD_STAT_MEAS_LSB +: 16]         = meas_r;
         end
         default:             rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= '0;
         s_axi_rresp_o  <= `CSDD_RESP_OKAY;
      end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o  <= rd_word;
         s_axi_rresp_o  <= rd_hit ? `CSDD_RESP_OKAY : `CSDD_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // --------------------
   // setting registers
   // --------------------
   logic [31:0] div_nxt;
   logic [31:0] ctrl_nxt;

   assign div_nxt  = merge({16'h0000, div_r}, wdata_r, wstrb_r);
   assign ctrl_nxt = merge(ctrl_word, wdata_r, wstrb_r);

   // B and C take the strap once it has settled; a write in that cycle loses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r <= {CSDD_DIV1, CSDD_DIV4, CSDD_DIV4, CSDD_DIV1};
      end else if (strap_load) begin
         div_r[4 +: 8] <= strap_sync_r ? {CSDD_DIV4, CSDD_DIV4}
                                       : {CSDD_DIV3, CSDD_DIV3};
      end else if (do_write && {awaddr_r[7:2], 2'b00} == `CSDD_OFF_DIV) begin
         div_r <= div_nxt[15:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cdly_r <= '0;
      end else if (do_write && {awaddr_r[7:2], 2'b00} == `CSDD_OFF_CLK_DELAY) begin
         cdly_r <= merge(cdly_r, wdata_r, wstrb_r);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdly_r <= '0;
      end else if (do_write && {awaddr_r[7:2], 2'b00} == `CSDD_OFF_REF_DELAY) begin
         rdly_r <= 24'(merge({8'h00, rdly_r}, wdata_r, wstrb_r));
      end
   end

   // sysref outputs start disabled, clocks start powered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ch_pd_r  <= '0;
         ref_pd_r <= 1'b0;
         ref_en_r <= '0;
         mult_r   <= '0;
      end else if (do_write && {awaddr_r[7:2], 2'b00} == `CSDD_OFF_CTRL) begin
         ch_pd_r  <= ctrl_nxt[`CSDD_CTRL_PD_LSB +: NUM_CH];
         ref_pd_r <= ctrl_nxt[`CSDD_CTRL_REFPD_BIT];
         ref_en_r <= ctrl_nxt[`CSDD_CTRL_REFEN_LSB +: NUM_REF];
         mult_r   <= ctrl_nxt[`CSDD_CTRL_MULT_LSB +: 2];
      end
   end

   // --------------------
   // delay calibration
   // --------------------
   csdd_cal_state_t  cal_state_r;
   logic [CAL_W-1:0] cal_cnt_r;
   csdd_mult_t       fdiv_cnt_r;
   logic             cal_set;
   logic             cal_end;

   assign cal_set = do_write && {awaddr_r[7:2], 2'b00} == `CSDD_OFF_CTRL
                    && wstrb_r[1] && wdata_r[`CSDD_CTRL_CAL_BIT];
   assign cal_end = (cal_state_r == CSDD_CAL_RUN)
                    && (cal_cnt_r == CAL_W'(CAL_CYCLES - 1));

   // the input clock paces the run, so it is the reference
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_state_r <= CSDD_CAL_IDLE;
         cal_cnt_r   <= '0;
      end else begin
         unique case (cal_state_r)
            CSDD_CAL_IDLE: begin
               cal_cnt_r <= '0;
               if (cal_start_r) begin
                  cal_state_r <= CSDD_CAL_RUN;
               end
            end
            CSDD_CAL_RUN: begin
               cal_cnt_r <= cal_cnt_r + CAL_W'(1);
               if (cal_end) begin
                  cal_state_r <= CSDD_CAL_IDLE;
               end
            end
         endcase
      end
   end

   // a fresh start request in the ending cycle survives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_start_r <= 1'b0;
      end else if (cal_set) begin
         cal_start_r <= 1'b1;
      end else if (cal_end) begin
         cal_start_r <= 1'b0;
      end
   end

   // final divider runs at the multiplier ratio only while calibrating
   always_ff @(posedge clk_i) begin
      if (rst_i || cal_state_r == CSDD_CAL_IDLE) begin
         fdiv_cnt_r <= '0;
      end else if (fdiv_cnt_r == mult_r) begin
         fdiv_cnt_r <= '0;
      end else begin
         fdiv_cnt_r <= fdiv_cnt_r + 2'd1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meas_r <= '0;
      end else if (cal_state_r == CSDD_CAL_IDLE && cal_start_r) begin
         meas_r <= '0;
      end else if (cal_state_r == CSDD_CAL_RUN && fdiv_cnt_r == mult_r) begin
         meas_r <= meas_r + 16'h0001;
      end
   end

   // unit is latched at the end and holds until the next calibration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unit_r     <= '0;
         cal_done_r <= 1'b0;
      end else if (cal_end) begin
         unit_r     <= mult_r;
         cal_done_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         calibration_oscillator_o <= 1'b0;
      end else begin
         calibration_oscillator_o <= (cal_state_r == CSDD_CAL_RUN) && !cal_end;
      end
   end

   // --------------------
   // clock channels
   // --------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      csdd_channel #(
         .DELAY_STEPS (DELAY_STEPS),
         .CNT_W       (5)
      ) u_ch (
         .clk_i        (clk_i),
         .rst_i        (rst_i),
         .div_code_i   (csdd_div_code_t'(div_r[c*`CSDD_DIV_W +: `CSDD_DIV_W])),
         .delay_i      (cdly_r[c*`CSDD_CLK_DELAY_W +: CD_W]),
         .power_down_i (ch_pd_r[c]),
         .clk_out_o    (channel_clock_output_o[c]),
         .divider_on_o (div_on[c])
      );
   end

   // --------------------
   // sysref fan-out and delay
   // --------------------
   logic               sref_meta_r;
   logic               sref_sync_r;
   logic [TAP_MAX:0]   sref_line_r;

   // phase relation to the clock is only as good as the source keeps it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sref_meta_r <= 1'b0;
         sref_sync_r <= 1'b0;
      end else begin
         sref_meta_r <= sysref_i;
         sref_sync_r <= sref_meta_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || ref_pd_r) begin
         sref_line_r <= '0;
      end else begin
         sref_line_r <= {sref_line_r[TAP_MAX-1:0], sref_sync_r};
      end
   end

   // one shared line: equal codes pick the same tap and switch together
   for (genvar r = 0; r < NUM_REF; r++) begin : g_ref
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            sysref_output_o[r] <= 1'b0;
         end else begin
            sysref_output_o[r] <= ref_en_r[r] & ~ref_pd_r
               & sref_line_r[tap_of(rdly_r[r*`CSDD_REF_DELAY_W +: 3], unit_r)];
         end
      end
   end

endmodule : clock_sysref_divider_delay

// ===== verification/csdd_sysref_gen.sv
// sysref source model driving the sysref pin
`timescale 1ns/1ps
module csdd_sysref_gen #(
   parameter int PULSE = 4
) (
   // clock and trigger
   input  wire logic clk_i,
   input  wire logic fire_i,
   // sysref pin
   output logic      sysref_o
);
   int left = 0;
   // launched on the clock edge, so sysref keeps a fixed phase to the clock
   always @(posedge clk_i) begin
      if (fire_i) left <= PULSE;
      else if (left > 0) left <= left - 1;
   end
   assign sysref_o = (left > 0);
endmodule : csdd_sysref_gen

// ===== verification/csdd_chk_sva.sv
// port checker for the clock and sysref distribution block
`timescale 1ns/1ps
module csdd_chk #(
   parameter int NUM_CH     = 4,
   parameter int NUM_REF    = 8,
   parameter int CAL_CYCLES = 8
) (
   // clock and reset
   input wire logic               clk_i,
   input wire logic               rst_i,
   // bus answers
   input wire logic               s_axi_bvalid_o,
   input wire logic               s_axi_bready_i,
   input wire logic [1:0]         s_axi_bresp_o,
   input wire logic               s_axi_arready_o,
   input wire logic               s_axi_rvalid_o,
   input wire logic               s_axi_rready_i,
   input wire logic [31:0]        s_axi_rdata_o,
   // pins
   input wire logic               sysref_i,
   input wire logic [NUM_CH-1:0]  channel_clock_output_o,
   input wire logic [NUM_REF-1:0] sysref_output_o,
   input wire logic               calibration_oscillator_o
);
   logic [15:0] osc_cnt_r;
   logic [7:0]  ref_age_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // run length of the oscillator
   always_ff @(posedge clk_i) begin
      if (rst_i || !calibration_oscillator_o) osc_cnt_r <= 16'h0;
      else osc_cnt_r <= osc_cnt_r + 16'h1;
   end
   // cycles since sysref was high, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i || sysref_i) ref_age_r <= 8'h00;
      else if (ref_age_r != 8'hff) ref_age_r <= ref_age_r + 8'h01;
   end
   chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp lost");
   chk_bvalid_clear: assert property (s_axi_bvalid_o && s_axi_bready_i
      |=> !s_axi_bvalid_o) else $error("bvalid stuck");
   chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata lost");
   chk_rvalid_clear: assert property (s_axi_rvalid_o && s_axi_rready_i
      |=> !s_axi_rvalid_o) else $error("rvalid stuck");
   chk_read_single: assert property (s_axi_arready_o == !s_axi_rvalid_o)
      else $error("read overlap");
   chk_reset_quiet: assert property ($fell(rst_i) |-> channel_clock_output_o == '0
      && sysref_output_o == '0 && !calibration_oscillator_o) else $error("reset output");
   chk_osc_bounded: assert property (calibration_oscillator_o
      |-> osc_cnt_r <= 16'(CAL_CYCLES + 1)) else $error("oscillator runs on");
   chk_sysref_cause: assert property (sysref_output_o != '0 |-> ref_age_r < 8'd40)
      else $error("sysref without input");
endmodule : csdd_chk
bind clock_sysref_divider_delay csdd_chk #(.NUM_CH(NUM_CH), .NUM_REF(NUM_REF),
   .CAL_CYCLES(CAL_CYCLES)) u_chk (.*);

// ===== verification/clock_sysref_divider_delay_tb_top.sv
// self-checking bench for the clock and sysref distribution block
`timescale 1ns/1ps
`include "csdd_map.svh"
module clock_sysref_divider_delay_tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1, strap = 1'b0, fire = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ref_out;
   logic [31:0] wdata = 32'h0, rd, rdata;
   logic        awready, wready, bvalid, arready, rvalid, osc, sysref;
   logic [1:0]  bresp, rresp, rr;
   logic [3:0]  clk_out;
   int          failures = 0, checks = 0, cyc = 0, n, t0, t1;
   int          ratio[9] = '{1, 2, 3, 4, 6, 8, 12, 16, 24};
   always #12.5 clk_i = ~clk_i;
   // the run needs about 1000 cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         failures++;
         tally_and_finish();
      end
   end
   clock_sysref_divider_delay #(.CAL_CYCLES(8)) DUT (.clk_i(clk_i), .rst_i(rst_i),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .bc_divider_default_select_i(strap),
      .sysref_i(sysref), .channel_clock_output_o(clk_out), .sysref_output_o(ref_out),
      .calibration_oscillator_o(osc));
   csdd_sysref_gen GEN (.clk_i(clk_i), .fire_i(fire), .sysref_o(sysref));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_i);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check(32'(bresp), 32'(er));
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge clk_i);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0; rd = rdata; rr = rresp;
   endtask : rdr
   task automatic do_reset(input logic s);
      @(posedge clk_i);
      rst_i <= 1'b1; strap <= s;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : do_reset
   // pulses of channel b in 48 cycles
   task automatic count(output int p);
      p = 0;
      repeat (48) begin
         @(posedge clk_i);
         #1;
         if (clk_out[1] === 1'b1) p++;
         check(32'(clk_out[1]), 32'(clk_out[2]));
      end
   endtask : count
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   initial begin
      do_reset(1'b0);
      rdr(`CSDD_OFF_DIV);
      check(rd, 32'h0000_0220);
      do_reset(1'b1);
      rdr(`CSDD_OFF_DIV);
      check(rd, 32'h0000_0330);
      $display("test reset defaults done");
      wr(`CSDD_OFF_CLK_DELAY, 32'hff05_0500, 2'b00);
      rdr(`CSDD_OFF_CLK_DELAY);
      check(rd, 32'hff05_0500);
      wr(`CSDD_OFF_REF_DELAY, 32'h00fa_c688, 2'b00);
      rdr(`CSDD_OFF_REF_DELAY);
      check(rd, 32'h00fa_c688);
      wr(`CSDD_OFF_STATUS, 32'hffff_ffff, 2'b10);
      rdr(8'h20);
      check({rd[29:0], rr}, 32'h2);
      $display("test registers done");
      for (int i = 0; i < 9; i++) begin
         wr(`CSDD_OFF_DIV, {20'h0, 4'(i), 4'(i), 4'h0}, 2'b00);
         repeat (30) @(posedge clk_i);
         count(n);
         check(32'(n), 32'(48 / ratio[i]));
         rdr(`CSDD_OFF_STATUS);
         check(32'(rd[9]), 32'(i != 0));
      end
      wr(`CSDD_OFF_CTRL, 32'h0000_0006, 2'b00);
      repeat (30) @(posedge clk_i);
      count(n);
      check(32'(n), 32'h0);
      $display("test dividers done");
      wr(`CSDD_OFF_CTRL, 32'h0000_c000, 2'b00);
      repeat (3) @(posedge clk_i);
      check(32'(osc), 32'h1);
      repeat (12) @(posedge clk_i);
      rdr(`CSDD_OFF_CTRL);
      check(32'(rd[15]), 32'h0);
      rdr(`CSDD_OFF_STATUS);
      check(32'(rd[3:0]), 32'h9);
      $display("test calibration done");
      wr(`CSDD_OFF_REF_DELAY, 32'h0000_0008, 2'b00);
      wr(`CSDD_OFF_CTRL, 32'h0000_40e0, 2'b00);
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      t0 = 99;
      t1 = 99;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk_i);
         #1;
         if (ref_out[0] === 1'b1 && t0 == 99) t0 = k;
         if (ref_out[1] === 1'b1 && t1 == 99) t1 = k;
         check(32'(ref_out[0]), 32'(ref_out[2]));
      end
      check(32'(t1 - t0), 32'd3);
      $display("test sysref done");
      tally_and_finish();
   end
endmodule : clock_sysref_divider_delay_tb_top
